// *** common/addr_decoder_pkg.sv ***
package addr_decoder_pkg;

	// address spaces: 64 GB of memory, 64 KB plus three bytes of I/O
	localparam int ADDR_W  = 36;
	localparam int IO_W    = 17;
	localparam int NUM_PAM = 13;
	localparam int NUM_WIN = 11;
	localparam logic [IO_W-1:0] IO_SPACE_TOP = 17'h1_0002;

	// fixed memory landmarks
	localparam logic [ADDR_W-1:0] DOS_TOP        = 36'h0_000A_0000;
	localparam logic [ADDR_W-1:0] VGA_BASE       = 36'h0_000A_0000;
	localparam logic [ADDR_W-1:0] VGA_LIMIT      = 36'h0_000B_FFFF;
	localparam logic [ADDR_W-1:0] PAM_BASE       = 36'h0_000C_0000;
	localparam logic [ADDR_W-1:0] ONE_MB         = 36'h0_0010_0000;
	localparam logic [ADDR_W-1:0] ISA_HOLE_BASE  = 36'h0_00F0_0000;
	localparam logic [ADDR_W-1:0] ISA_HOLE_LIMIT = 36'h0_00FF_FFFF;
	localparam logic [ADDR_W-1:0] DRAM_MAX       = 36'h2_0000_0000;
	localparam logic [ADDR_W-1:0] DRAM_CEIL      = 36'h3_0000_0000;

	// window size masks
	localparam logic [ADDR_W-1:0] MASK_4KB   = 36'h0_0000_0FFF;
	localparam logic [ADDR_W-1:0] MASK_16KB  = 36'h0_0000_3FFF;
	localparam logic [ADDR_W-1:0] MASK_64MB  = 36'h0_03FF_FFFF;
	localparam logic [ADDR_W-1:0] MASK_128MB = 36'h0_07FF_FFFF;
	localparam logic [ADDR_W-1:0] MASK_256MB = 36'h0_0FFF_FFFF;
	localparam logic [1:0] CFG_SIZE_64MB  = 2'h0;
	localparam logic [1:0] CFG_SIZE_128MB = 2'h1;

	// attribute map of the legacy segments
	localparam int PAM_RE_BIT = 0;
	localparam int PAM_WE_BIT = 1;
	localparam int PAM_SEG_LSB = 14;
	localparam logic [5:0] PAM_FIRST_SEG = 6'h30;
	localparam logic [19:0] SYS_BIOS_BASE = 20'hF_0000;

	// legacy graphics steering
	localparam logic [1:0] VGA_TO_PORT_A = 2'h1;
	localparam logic [1:0] VGA_TO_PORT_B = 2'h2;

	// window slots, lower index wins on overlap
	localparam int WIN_PA_MEM   = 0;
	localparam int WIN_PA_PF    = 1;
	localparam int WIN_PA_IO    = 2;
	localparam int WIN_PB_MEM   = 3;
	localparam int WIN_PB_PF    = 4;
	localparam int WIN_PB_IO    = 5;
	localparam int WIN_EGRESS   = 6;
	localparam int WIN_REGS     = 7;
	localparam int WIN_CONFIG   = 8;
	localparam int WIN_LINK_REG = 9;
	localparam int WIN_FLUSH    = 10;

	typedef enum logic [1:0] {
		SRC_CPU, SRC_LINK, SRC_PORT_A, SRC_PORT_B
	} source_type;

	typedef enum logic [2:0] {
		TGT_DRAM, TGT_PORT_A, TGT_PORT_B, TGT_LINK, TGT_INTERNAL, TGT_ABORT
	} target_type;

	typedef enum logic [2:0] {
		IWIN_NONE, IWIN_EGRESS, IWIN_REGS, IWIN_CONFIG, IWIN_LINK_REGS,
		IWIN_FLUSH
	} internal_window_type;

	typedef struct packed {
		logic              valid;
		source_type        src;
		logic              is_io;
		logic              is_write;
		logic              smm_mode;
		logic [ADDR_W-1:0] addr;
	} request_type;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] limit;
	} window_type;

	typedef struct packed {
		logic              en;
		logic [ADDR_W-1:0] base;
	} fixed_window_type;

	typedef struct packed {
		logic [ADDR_W-1:0]    top_of_low_memory;
		logic [ADDR_W-1:0]    dram_top;
		logic                 remap_en;
		logic [ADDR_W-1:0]    remap_base;
		logic [ADDR_W-1:0]    remap_limit;
		logic                 smm_seg_en;
		logic [ADDR_W-1:0]    smm_seg_size;
		logic                 isa_hole_en;
		logic [1:0]           vga_steer;
		logic [2*NUM_PAM-1:0] pam_attr;
	} map_cfg_type;

	typedef struct packed {
		logic                valid;
		target_type          target;
		internal_window_type win;
		logic [ADDR_W-1:0]   dram_addr;
	} result_type;

	typedef struct packed {
		result_type res;
		logic       flush;
	} decode_state_type;

	localparam decode_state_type STATE_RESET = '0;

endpackage : addr_decoder_pkg

// *** hdl/pam_check.sv ***
`timescale 1ns/1ps
`default_nettype none

// attribute check of the thirteen legacy segments, 768 KB to 1 MB
module pam_check
	import addr_decoder_pkg::*;
(
	input  wire logic [19:0]          addr_i,     // low address bits
	input  wire logic [2*NUM_PAM-1:0] attr_i,     // two bits per segment
	input  wire logic                 is_write_i, // access is a write
	output logic                      in_area_o,  // inside attribute area
	output logic                      allowed_o   // attribute admits access
);

	logic [3:0] seg;
	logic [1:0] attr;

	// sixteen-kilobyte segments, last one spans the whole top 64 KB
	function automatic logic [3:0] segment_of(input logic [19:0] a);
		logic [5:0] idx;
		idx = a[19:PAM_SEG_LSB] - PAM_FIRST_SEG;
		if (a >= SYS_BIOS_BASE) begin
			return 4'(NUM_PAM - 1);
		end
		return idx[3:0];
	endfunction : segment_of

	// read enable and write enable are separate bits of each segment
	always_comb begin
		seg       = segment_of(addr_i);
		attr      = attr_i[{seg, 1'b0} +: 2];
		in_area_o = ({16'h0, addr_i} >= PAM_BASE);
		allowed_o = is_write_i ? attr[PAM_WE_BIT] : attr[PAM_RE_BIT];
	end

endmodule : pam_check

`default_nettype wire

// *** hdl/system_address_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

module system_address_decoder
	import addr_decoder_pkg::*;
(
	input  wire logic             clk_i,                           // clock
	input  wire logic             rst_n_i,                         // reset
	input  wire request_type      req_i,                           // request
	input  wire logic [1:0]       request_upper_address_bits_i,    // 4 GB
	input  wire map_cfg_type      cfg_i,                           // map
	input  wire window_type       port_a_memory_window_i,          // A mem
	input  wire window_type       port_a_prefetch_window_i,        // A pref
	input  wire window_type       port_a_io_window_i,              // A io
	input  wire window_type       port_b_memory_window_i,          // B mem
	input  wire window_type       port_b_prefetch_window_i,        // B pref
	input  wire window_type       port_b_io_window_i,              // B io
	input  wire fixed_window_type egress_port_window_base_i,       // 4 KB
	input  wire fixed_window_type internal_register_window_base_i, // 16 KB
	input  wire fixed_window_type flat_config_window_base_i,       // config
	input  wire logic [1:0]       flat_config_size_i,              // size
	input  wire fixed_window_type link_register_window_base_i,     // 4 KB
	input  wire fixed_window_type write_flush_window_base_i,       // 4 KB
	output result_type            result_o,                        // route
	output logic                  flush_o                          // pulse
);

	decode_state_type    state_r;
	decode_state_type    state_nxt;
	window_type          win     [NUM_WIN];
	logic [NUM_WIN-1:0]  win_hit;
	logic [ADDR_W-1:0]   io_addr;
	logic [ADDR_W-1:0]   addr;
	logic [ADDR_W-1:0]   cfg_mask;
	logic [ADDR_W-1:0]   smm_base;
	logic [ADDR_W-1:0]   remap_phys;
	logic                above_4g;
	logic                pam_in_area;
	logic                pam_allowed;
	logic                remap_hit;
	logic                high_dram;
	logic                low_dram;
	logic                in_vga;
	logic                peer_ok;

	// inclusive range test, shared by the graphics, ISA hole and remap checks
	function automatic logic in_range(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	// a fixed window claims its naturally aligned block
	function automatic window_type fixed_win(input fixed_window_type f,
		input logic [ADDR_W-1:0] mask);
		window_type w;
		w.en    = f.en;
		w.base  = f.base & ~mask;
		w.limit = (f.base & ~mask) | mask;
		return w;
	endfunction : fixed_win

	// flat configuration window size
	always_comb begin
		case (flat_config_size_i)
			CFG_SIZE_64MB:  cfg_mask = MASK_64MB;
			CFG_SIZE_128MB: cfg_mask = MASK_128MB;
			default:        cfg_mask = MASK_256MB;
		endcase
	end

	// window table; prefetchable windows keep all upper bits
	assign win[WIN_PA_MEM]   = port_a_memory_window_i;
	assign win[WIN_PA_PF]    = port_a_prefetch_window_i;
	assign win[WIN_PA_IO]    = port_a_io_window_i;
	assign win[WIN_PB_MEM]   = port_b_memory_window_i;
	assign win[WIN_PB_PF]    = port_b_prefetch_window_i;
	assign win[WIN_PB_IO]    = port_b_io_window_i;
	assign win[WIN_EGRESS]   = fixed_win(egress_port_window_base_i,
		MASK_4KB);
	assign win[WIN_REGS]     = fixed_win(internal_register_window_base_i,
		MASK_16KB);
	assign win[WIN_CONFIG]   = fixed_win(flat_config_window_base_i,
		cfg_mask);
	assign win[WIN_LINK_REG] = fixed_win(link_register_window_base_i,
		MASK_4KB);
	assign win[WIN_FLUSH]    = fixed_win(write_flush_window_base_i,
		MASK_4KB);

	// i/o address keeps 17 bits, so accesses up to three bytes past 64 KB do not wrap
	assign io_addr  = {{(ADDR_W-IO_W){1'b0}}, req_i.addr[IO_W-1:0]};
	assign addr     = req_i.addr;
	assign above_4g = |request_upper_address_bits_i;

	// one comparator per window; i/o windows see the i/o address
	genvar k;
	generate
		for (k = 0; k < NUM_WIN; k++) begin : g_win
			localparam bit IS_IO = (k == WIN_PA_IO) || (k == WIN_PB_IO);
			localparam bit IS_NP = (k == WIN_PA_MEM) || (k == WIN_PB_MEM);
			logic raw_hit;
			window_match #(
				.W(ADDR_W)
			) u_match (
				.en_i    (win[k].en),
				.addr_i  (IS_IO ? io_addr : addr),
				.base_i  (win[k].base),
				.limit_i (win[k].limit),
				.hit_o   (raw_hit)
			);
			// non-prefetchable windows live below 4 GB only
			assign win_hit[k] = raw_hit && (IS_IO == req_i.is_io) &&
				!(IS_NP && above_4g);
		end
	endgenerate

	pam_check u_pam (
		.addr_i     (addr[19:0]),
		.attr_i     (cfg_i.pam_attr),
		.is_write_i (req_i.is_write),
		.in_area_o  (pam_in_area),
		.allowed_o  (pam_allowed)
	);

	// memory decode: landmarks below 1 MB, low DRAM, remap, high DRAM
	always_comb begin
		smm_base   = cfg_i.top_of_low_memory - cfg_i.smm_seg_size;
		remap_phys = addr - cfg_i.remap_base + cfg_i.top_of_low_memory;
		in_vga     = !above_4g && in_range(addr, VGA_BASE, VGA_LIMIT);
		remap_hit  = cfg_i.remap_en && above_4g && addr < DRAM_CEIL &&
			in_range(addr, cfg_i.remap_base, cfg_i.remap_limit);
		// no size check: DRAM past the ceiling just never decodes
		high_dram  = above_4g && !remap_hit && addr < cfg_i.dram_top &&
			addr < DRAM_MAX && addr < DRAM_CEIL;
		low_dram   = 1'b0;
		if (!above_4g && addr < DOS_TOP) begin
			low_dram = 1'b1;
		end else if (!above_4g && addr < ONE_MB && pam_in_area) begin
			low_dram = pam_allowed;
		end else if (!above_4g && addr >= ONE_MB &&
			addr < cfg_i.top_of_low_memory) begin
			low_dram = 1'b1;
			if (cfg_i.isa_hole_en &&
				in_range(addr, ISA_HOLE_BASE, ISA_HOLE_LIMIT)) begin
				low_dram = 1'b0;
			end
			if (cfg_i.smm_seg_en && addr >= smm_base &&
				!(req_i.smm_mode && req_i.src == SRC_CPU)) begin
				low_dram = 1'b0;
			end
		end
	end

	// peers below low-memory top: only link writes to graphics
	assign peer_ok = (req_i.src == SRC_CPU) || above_4g ||
		addr >= cfg_i.top_of_low_memory ||
		(req_i.src == SRC_LINK && req_i.is_write && in_vga);

	// route selection, registered one cycle later
	always_comb begin
		state_nxt               = state_r;
		state_nxt.flush         = 1'b0;
		state_nxt.res.valid     = req_i.valid;
		state_nxt.res.target    = TGT_LINK;
		state_nxt.res.win       = IWIN_NONE;
		state_nxt.res.dram_addr = addr;
		if (req_i.is_io) begin
			if (win_hit[WIN_PA_IO]) begin
				state_nxt.res.target = TGT_PORT_A;
			end else if (win_hit[WIN_PB_IO]) begin
				state_nxt.res.target = TGT_PORT_B;
			end
		end else if (low_dram || high_dram) begin
			state_nxt.res.target = TGT_DRAM;
		end else if (remap_hit && remap_phys < DRAM_MAX) begin
			state_nxt.res.target    = TGT_DRAM;
			state_nxt.res.dram_addr = remap_phys;
		end else if (in_vga) begin
			case (cfg_i.vga_steer)
				VGA_TO_PORT_A: state_nxt.res.target = TGT_PORT_A;
				VGA_TO_PORT_B: state_nxt.res.target = TGT_PORT_B;
				default:       state_nxt.res.target = TGT_LINK;
			endcase
		end else if (above_4g || addr >= cfg_i.top_of_low_memory) begin
			// overlaps are not guarded; lowest slot simply wins
			for (int i = NUM_WIN - 1; i >= 0; i--) begin
				if (win_hit[i]) begin
					case (i)
						WIN_PA_MEM, WIN_PA_PF: begin
							state_nxt.res.target = TGT_PORT_A;
							state_nxt.res.win    = IWIN_NONE;
						end
						WIN_PB_MEM, WIN_PB_PF: begin
							state_nxt.res.target = TGT_PORT_B;
							state_nxt.res.win    = IWIN_NONE;
						end
						WIN_EGRESS: begin
							state_nxt.res.target = TGT_INTERNAL;
							state_nxt.res.win    = IWIN_EGRESS;
						end
						WIN_REGS: begin
							state_nxt.res.target = TGT_INTERNAL;
							state_nxt.res.win    = IWIN_REGS;
						end
						WIN_CONFIG: begin
							state_nxt.res.target = TGT_INTERNAL;
							state_nxt.res.win    = IWIN_CONFIG;
						end
						WIN_LINK_REG: begin
							state_nxt.res.target = TGT_INTERNAL;
							state_nxt.res.win    = IWIN_LINK_REGS;
						end
						default: begin
							state_nxt.res.target = TGT_INTERNAL;
							state_nxt.res.win    = IWIN_FLUSH;
						end
					endcase
				end
			end
		end
		// a forbidden peer cycle is aborted rather than forwarded
		if (!req_i.is_io && !peer_ok &&
			(state_nxt.res.target == TGT_PORT_A ||
			 state_nxt.res.target == TGT_PORT_B)) begin
			state_nxt.res.target = TGT_ABORT;
		end
		state_nxt.flush = req_i.valid && req_i.is_write &&
			state_nxt.res.win == IWIN_FLUSH;
	end

	// single state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= STATE_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign result_o = state_r.res;
	assign flush_o  = state_r.flush;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_mem_req;
		req_i.valid && !req_i.is_io;
	endsequence

	sequence s_remap_req;
		s_mem_req ##0 remap_hit ##0 (remap_phys < DRAM_MAX) &&
			!low_dram && !high_dram;
	endsequence

	a_dos_to_dram: assert property (
		s_mem_req ##0 (!above_4g && addr < DOS_TOP) |=>
			result_o.valid && result_o.target == TGT_DRAM)
		else $error("low 640 KB not routed to DRAM");

	a_remap_translate: assert property (
		s_remap_req |=> result_o.target == TGT_DRAM &&
			result_o.dram_addr == $past(addr) - $past(cfg_i.remap_base) +
			$past(cfg_i.top_of_low_memory))
		else $error("remap window translated wrongly");

	a_dram_ceiling: assert property (
		result_o.valid && result_o.target == TGT_DRAM &&
			$past(above_4g) |-> result_o.dram_addr < DRAM_MAX &&
			$past(addr) < DRAM_CEIL)
		else $error("DRAM reached above the ceiling");

	a_pam_disabled: assert property (
		s_mem_req ##0 (!above_4g && pam_in_area && addr < ONE_MB &&
			!pam_allowed) |=> result_o.target == TGT_LINK)
		else $error("disabled segment not sent to link");

	a_vga_steer: assert property (
		s_mem_req ##0 (in_vga && req_i.src == SRC_CPU &&
			cfg_i.vga_steer == VGA_TO_PORT_B) |=>
			result_o.target == TGT_PORT_B)
		else $error("graphics range not steered to port B");

	a_peer_block: assert property (
		s_mem_req ##0 (req_i.src != SRC_CPU && !above_4g &&
			addr < cfg_i.top_of_low_memory && !req_i.is_write) |=>
			result_o.target != TGT_PORT_A && result_o.target != TGT_PORT_B)
		else $error("forbidden peer cycle forwarded");

	a_flush_pulse: assert property (
		flush_o |-> $past(req_i.is_write) && $past(win_hit[WIN_FLUSH]) &&
			result_o.win == IWIN_FLUSH ##1 !flush_o || $past(req_i.valid))
		else $error("flush pulse without a flush write");

	a_isa_hole: assert property (
		s_mem_req ##0 (!above_4g && cfg_i.isa_hole_en &&
			in_range(addr, ISA_HOLE_BASE, ISA_HOLE_LIMIT) &&
			ISA_HOLE_LIMIT < cfg_i.top_of_low_memory) |=>
			result_o.target != TGT_DRAM)
		else $error("ISA hole reached DRAM");

	a_io_port_a: assert property (
		req_i.valid && req_i.is_io && win_hit[WIN_PA_IO] |=>
			result_o.target == TGT_PORT_A)
		else $error("port A i/o window not claimed");

	a_default_link: assert property (
		s_mem_req ##0 (above_4g && !remap_hit && !high_dram &&
			win_hit == '0) |=> result_o.target == TGT_LINK)
		else $error("unclaimed access not sent to link");

endmodule : system_address_decoder

`default_nettype wire

// *** hdl/window_match.sv ***
`timescale 1ns/1ps
`default_nettype none

// inclusive base-to-limit compare of one programmable window
module window_match #(
	parameter int W = 36
) (
	input  wire logic         en_i,    // window enabled
	input  wire logic [W-1:0] addr_i,  // address under test
	input  wire logic [W-1:0] base_i,  // lowest claimed address
	input  wire logic [W-1:0] limit_i, // highest claimed address
	output logic              hit_o    // address inside window
);

	// limit below base gives an empty window, never a wrap
	assign hit_o = en_i && (addr_i >= base_i) && (addr_i <= limit_i);

endmodule : window_match

`default_nettype wire

// *** verification/bus_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// request source on the processor bus side of the decoder
module bus_source_model
	import addr_decoder_pkg::*;
(
	input  wire logic              valid_i, // request this cycle
	input  wire source_type        src_i,   // requester
	input  wire logic              write_i, // write cycle
	input  wire logic              smm_i,   // smm mode
	input  wire logic              io_i,    // io space
	input  wire logic [ADDR_W-1:0] addr_i,  // address
	output request_type            req_o,   // request phase
	output logic [1:0]             upper_o  // upper address bits
);
	logic [ADDR_W-1:0] bus_addr;

	// idle bus shows inverted address so a stale value never matches
	assign bus_addr = valid_i ? addr_i : ~addr_i;
	assign req_o = '{valid: valid_i, src: src_i, is_io: io_i,
		is_write: write_i, smm_mode: smm_i, addr: bus_addr};
	// upper bits flag any address at or above 4 GB
	assign upper_o = {|bus_addr[35:34], |bus_addr[33:32]};
endmodule : bus_source_model

`default_nettype wire

// *** verification/system_address_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module system_address_decoder_tb_top
	import addr_decoder_pkg::*;
;
	logic              clk_i, rst_n_i, cmd_valid, cmd_wr, cmd_smm, cmd_io;
	source_type        cmd_src;
	logic [ADDR_W-1:0] cmd_addr;
	request_type       req;
	logic [1:0]        upper, cfg_size;
	map_cfg_type       cfg;
	window_type        pa_m, pa_p, pa_i, pb_m, pb_p, pb_i;
	fixed_window_type  eg, rg, cf, lk, fl;
	result_type        res;
	logic              flush;
	int                bad_count, checks_done, cycles;

	bus_source_model src (.valid_i(cmd_valid), .src_i(cmd_src),
		.write_i(cmd_wr), .smm_i(cmd_smm), .io_i(cmd_io),
		.addr_i(cmd_addr), .req_o(req), .upper_o(upper));

	system_address_decoder dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.req_i(req), .request_upper_address_bits_i(upper), .cfg_i(cfg),
		.port_a_memory_window_i(pa_m), .port_a_prefetch_window_i(pa_p),
		.port_a_io_window_i(pa_i), .port_b_memory_window_i(pb_m),
		.port_b_prefetch_window_i(pb_p), .port_b_io_window_i(pb_i),
		.egress_port_window_base_i(eg),
		.internal_register_window_base_i(rg),
		.flat_config_window_base_i(cf), .flat_config_size_i(cfg_size),
		.link_register_window_base_i(lk), .write_flush_window_base_i(fl),
		.result_o(res), .flush_o(flush));

	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// hang guard, the whole run needs well under 200 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
			results();
		end
	end

	task automatic cmp(input logic [ADDR_W-1:0] got,
			input logic [ADDR_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// one request per cycle; valid stays up so calls run back to back
	task automatic go(input source_type s, input logic w,
			input logic [ADDR_W-1:0] a, input target_type t,
			input internal_window_type wn);
		logic [ADDR_W-1:0] da;
		da = a;
		if (cfg.remap_en && a >= cfg.remap_base && a <= cfg.remap_limit)
			da = a - cfg.remap_base + cfg.top_of_low_memory;
		cmd_valid = 1'b1;
		cmd_src = s;
		cmd_wr = w;
		cmd_addr = a;
		@(posedge clk_i);
		#1;
		cmp(ADDR_W'(res.valid), 36'h1);
		cmp(ADDR_W'(res.target), ADDR_W'(t));
		cmp(ADDR_W'(res.win), ADDR_W'(wn));
		if (t == TGT_DRAM)
			cmp(res.dram_addr, da);
		cmp(ADDR_W'(flush), ADDR_W'(w && wn == IWIN_FLUSH));
	endtask : go

	// idle cycle: result and flush must fall back
	task automatic done(input string name);
		cmd_valid = 1'b0;
		@(posedge clk_i);
		#1;
		cmp(ADDR_W'(res.valid), 36'h0);
		cmp(ADDR_W'(flush), 36'h0);
		$display("test %s finished", name);
	endtask : done

	task automatic t_low();
		go(SRC_CPU, 1'b0, 36'h0_0009_FFFF, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b1, 36'h0_0010_0000, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_00F0_0000, TGT_LINK, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_7FEF_FFFF, TGT_DRAM, IWIN_NONE);
		cmd_smm = 1'b1;
		go(SRC_CPU, 1'b0, 36'h0_7FF0_0000, TGT_DRAM, IWIN_NONE);
		cmd_smm = 1'b0;
		go(SRC_CPU, 1'b0, 36'h0_7FFF_FFFF, TGT_LINK, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_F000_0000, TGT_LINK, IWIN_NONE);
		done("low");
	endtask : t_low

	// every attribute code on the first legacy segment
	task automatic t_pam();
		for (int c = 0; c < 4; c++) begin
			cfg.pam_attr[1:0] = c[1:0];
			go(SRC_CPU, 1'b0, 36'h0_000C_0000,
				c[0] ? TGT_DRAM : TGT_LINK, IWIN_NONE);
			go(SRC_CPU, 1'b1, 36'h0_000C_3FFF,
				c[1] ? TGT_DRAM : TGT_LINK, IWIN_NONE);
			go(SRC_CPU, 1'b1, 36'h0_000C_4000, TGT_LINK, IWIN_NONE);
		end
		done("pam");
	endtask : t_pam

	task automatic t_vga();
		cfg.vga_steer = 2'h0;
		go(SRC_CPU, 1'b0, 36'h0_000A_0000, TGT_LINK, IWIN_NONE);
		cfg.vga_steer = VGA_TO_PORT_B;
		go(SRC_CPU, 1'b0, 36'h0_000B_0000, TGT_PORT_B, IWIN_NONE);
		cfg.vga_steer = VGA_TO_PORT_A;
		go(SRC_CPU, 1'b1, 36'h0_000A_0000, TGT_PORT_A, IWIN_NONE);
		go(SRC_LINK, 1'b1, 36'h0_000B_FFFF, TGT_PORT_A, IWIN_NONE);
		go(SRC_LINK, 1'b0, 36'h0_000A_0000, TGT_ABORT, IWIN_NONE);
		go(SRC_PORT_B, 1'b1, 36'h0_000A_0000, TGT_ABORT, IWIN_NONE);
		done("vga");
	endtask : t_vga

	task automatic t_high();
		go(SRC_CPU, 1'b0, 36'h1_0000_0000, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h1_8000_1000, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b1, 36'h1_BFFF_FFFF, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h1_C000_0000, TGT_LINK, IWIN_NONE);
		cfg.remap_en = 1'b0;
		cfg.dram_top = 36'h3_8000_0000;
		go(SRC_CPU, 1'b0, 36'h1_FFFF_FFF0, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h2_0000_0000, TGT_LINK, IWIN_NONE);
		go(SRC_CPU, 1'b1, 36'h3_0000_0000, TGT_LINK, IWIN_NONE);
		cfg.remap_en = 1'b1;
		cfg.dram_top = 36'h1_8000_0000;
		done("high");
	endtask : t_high

	task automatic t_ports();
		go(SRC_CPU, 1'b0, 36'h0_9000_0000, TGT_PORT_A, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h4_0000_0000, TGT_PORT_A, IWIN_NONE);
		go(SRC_LINK, 1'b1, 36'h4_FFFF_FFFF, TGT_PORT_A, IWIN_NONE);
		go(SRC_CPU, 1'b1, 36'h5_0000_0000, TGT_PORT_B, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_7000_0000, TGT_DRAM, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_8000_0000, TGT_PORT_B, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_A000_0000, TGT_LINK, IWIN_NONE);
		cmd_io = 1'b1;
		go(SRC_CPU, 1'b0, 36'h0_0000_1000, TGT_PORT_A, IWIN_NONE);
		go(SRC_CPU, 1'b1, 36'h0_0001_0002, TGT_PORT_B, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_0000_3000, TGT_LINK, IWIN_NONE);
		cmd_io = 1'b0;
		done("ports");
	endtask : t_ports

	task automatic t_fixed();
		go(SRC_CPU, 1'b0, 36'h0_E000_0FFF, TGT_INTERNAL, IWIN_EGRESS);
		go(SRC_CPU, 1'b0, 36'h0_E000_1000, TGT_LINK, IWIN_NONE);
		go(SRC_CPU, 1'b0, 36'h0_E001_3FFF, TGT_INTERNAL, IWIN_REGS);
		go(SRC_CPU, 1'b1, 36'h0_E002_0000, TGT_INTERNAL, IWIN_LINK_REGS);
		go(SRC_CPU, 1'b1, 36'h0_E003_0FFF, TGT_INTERNAL, IWIN_FLUSH);
		go(SRC_CPU, 1'b1, 36'h0_E003_0000, TGT_INTERNAL, IWIN_FLUSH);
		go(SRC_CPU, 1'b0, 36'h0_E003_0000, TGT_INTERNAL, IWIN_FLUSH);
		for (int c = 0; c < 3; c++) begin
			cfg_size = c[1:0];
			go(SRC_CPU, 1'b0, 36'h0_C000_0000 + (36'h400_0000 << c) - 36'h1,
				TGT_INTERNAL, IWIN_CONFIG);
			go(SRC_CPU, 1'b0, 36'h0_C000_0000 + (36'h400_0000 << c),
				TGT_LINK, IWIN_NONE);
		end
		done("fixed");
	endtask : t_fixed

	// reset in mid-run drops a pending flush and the registered route
	task automatic t_reset();
		go(SRC_CPU, 1'b1, 36'h0_E003_0000, TGT_INTERNAL, IWIN_FLUSH);
		rst_n_i = 1'b0;
		#1;
		cmp(ADDR_W'(res.valid), 36'h0);
		cmp(ADDR_W'(flush), 36'h0);
		@(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		go(SRC_CPU, 1'b0, 36'h0_0000_1000, TGT_DRAM, IWIN_NONE);
		done("reset");
	endtask : t_reset

	initial begin
		rst_n_i = 1'b0;
		{cmd_valid, cmd_wr, cmd_smm, cmd_io} = 4'h0;
		cmd_src = SRC_CPU;
		cmd_addr = '0;
		cfg = '0;
		// disjoint windows, one deliberate overlap with low DRAM
		cfg.top_of_low_memory = 36'h0_8000_0000;
		cfg.dram_top = 36'h1_8000_0000;
		cfg.remap_en = 1'b1;
		cfg.remap_base = 36'h1_8000_0000;
		cfg.remap_limit = 36'h1_BFFF_FFFF;
		cfg.smm_seg_en = 1'b1;
		cfg.smm_seg_size = 36'h0_0010_0000;
		cfg.isa_hole_en = 1'b1;
		pa_m = '{1'b1, 36'h0_9000_0000, 36'h0_9FFF_FFFF};
		pa_p = '{1'b1, 36'h4_0000_0000, 36'h4_FFFF_FFFF};
		pa_i = '{1'b1, 36'h0_0000_1000, 36'h0_0000_1FFF};
		pb_m = '{1'b1, 36'h0_7000_0000, 36'h0_8FFF_FFFF};
		pb_p = '{1'b1, 36'h5_0000_0000, 36'h5_FFFF_FFFF};
		pb_i = '{1'b1, 36'h0_0001_0000, 36'h0_0001_0002};
		eg = '{1'b1, 36'h0_E000_0000};
		rg = '{1'b1, 36'h0_E001_0000};
		lk = '{1'b1, 36'h0_E002_0000};
		fl = '{1'b1, 36'h0_E003_0000};
		cf = '{1'b1, 36'h0_C000_0000};
		cfg_size = 2'h2;
		repeat (12) @(posedge clk_i);
		#1;
		cmp(ADDR_W'(res.valid), 36'h0);
		cmp(ADDR_W'(res.target), ADDR_W'(TGT_DRAM));
		cmp(ADDR_W'(flush), 36'h0);
		rst_n_i = 1'b1;
		t_low();
		t_pam();
		t_vga();
		t_high();
		t_ports();
		t_fixed();
		t_reset();
		results();
	end
endmodule : system_address_decoder_tb_top

`default_nettype wire
